/* dmc_pkg.sv */
// dmc_pkg: register map, field layout and state type of one dma channel
// assumes a 16-bit register port with word indices on a 4-bit address
package dmc_pkg;
    localparam int          DW            = 16;
    localparam int          AW            = 4;
    localparam int          CW            = 10;
    localparam int          SW            = 7;
    localparam int          NREQ          = 128;
    localparam int          IW            = 2;
    // register indices
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_REQ       = 4'h1;
    localparam logic [3:0]  OFS_STA       = 4'h2;
    localparam logic [3:0]  OFS_STB       = 4'h3;
    localparam logic [3:0]  OFS_PAD       = 4'h4;
    localparam logic [3:0]  OFS_CNT       = 4'h5;
    localparam logic [3:0]  OFS_ISTAT     = 4'h6;
    localparam logic [3:0]  OFS_IEN       = 4'h7;
    localparam logic [3:0]  OFS_ICLR      = 4'h8;
    // field positions
    localparam int          CTRL_EN_BIT   = 15;
    localparam int          CTRL_AM_LSB   = 4;
    localparam int          CTRL_MD_LSB   = 0;
    localparam int          REQ_FORCE_BIT = 15;
    localparam int          MD_PP_BIT     = 1;
    localparam int          MD_OS_BIT     = 0;
    localparam int          IRQ_BLK_BIT   = 0;
    localparam int          IRQ_FIN_BIT   = 1;
    // addressing modes
    localparam logic [1:0]  AM_POSTINC    = 2'h0;
    localparam logic [1:0]  AM_NOINC      = 2'h1;
    localparam logic [1:0]  AM_PERIPH     = 2'h2;
    localparam logic [1:0]  AM_RSVD       = 2'h3;
    // operating modes
    localparam logic [1:0]  MD_CONT       = 2'h0;
    localparam logic [1:0]  MD_OS         = 2'h1;
    localparam logic [1:0]  MD_CONT_PP    = 2'h2;
    localparam logic [1:0]  MD_OS_PP      = 2'h3;
    // reset values and address step
    localparam logic [15:0] RST_REG       = 16'h0000;
    localparam logic [15:0] ADDR_STEP     = 16'h0001;

    typedef enum logic [0:0] {ST_IDLE, ST_BUSY} dmc_state_type;
endpackage

/* dmc_channel.sv */
// dmc_channel: one dma channel, mode and request select, buffer addressing
// assumes requests, transfer done and peripheral address come from logic
// on ref_clk; one transfer in flight at a time
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module dmc_channel (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    // register port
    input  wire logic [3:0]    reg_addr,
    input  wire logic [15:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [15:0]   reg_rdata,
    // peripheral side
    input  wire logic [127:0]  peripheral_request_lines,
    input  wire logic [15:0]   periph_ram_addr,
    // transfer engine
    output logic               xfer_valid,
    output logic      [15:0]   ram_addr,
    output logic      [15:0]   periph_addr,
    input  wire logic          xfer_done,
    // status
    output logic               channel_enable_bit,
    output logic               irq
);
    typedef struct packed {
        dmc_pkg::dmc_state_type state;
        logic                   en;
        logic [1:0]             amode;
        logic [1:0]             mode;
        logic                   force_x;
        logic                   fxfer;
        logic [6:0]             sel;
        logic [15:0]            sta;
        logic [15:0]            stb;
        logic [15:0]            pad;
        logic [9:0]             cnt;
        logic [15:0]            cur;
        logic [9:0]             done_n;
        logic                   buf_sel;
        logic [1:0]             istat;
        logic [1:0]             ien;
        logic [15:0]            rdata;
        logic                   xv;
        logic [15:0]            raddr;
        logic                   irq;
    } dmc_st_type;

    dmc_st_type r;
    dmc_st_type n;
    logic       channel_transfer_request;
    logic       pp;
    logic       os;
    logic       last;
    logic [1:0] ev;
    logic [15:0] ctrl_rd;

    always_comb begin
        n = r;
        ev = 2'h0;
        n.xv = 1'b0;
        n.rdata = dmc_pkg::RST_REG;
        channel_transfer_request = peripheral_request_lines[r.sel];
        pp = r.mode[dmc_pkg::MD_PP_BIT];
        os = r.mode[dmc_pkg::MD_OS_BIT];
        last = (r.done_n == r.cnt);
        ctrl_rd = dmc_pkg::RST_REG;
        ctrl_rd[dmc_pkg::CTRL_EN_BIT] = r.en;
        ctrl_rd[dmc_pkg::CTRL_AM_LSB +: 2] = r.amode;
        ctrl_rd[dmc_pkg::CTRL_MD_LSB +: 2] = r.mode;
        case (r.state)
            dmc_pkg::ST_IDLE: begin
                if (r.en && (r.force_x || channel_transfer_request)) begin
                    n.state = dmc_pkg::ST_BUSY;
                    n.xv = 1'b1;
                    // remember who started it, so a force written while a request-started transfer is busy survives the done
                    n.fxfer = r.force_x;
                    if (r.amode[1]) begin
                        n.raddr = periph_ram_addr;
                    end else begin
                        n.raddr = r.cur;
                    end
                end
            end
            dmc_pkg::ST_BUSY: begin
                if (xfer_done) begin
                    n.state = dmc_pkg::ST_IDLE;
                    if (r.fxfer) begin
                        n.force_x = 1'b0;
                    end
                    if (r.amode == dmc_pkg::AM_POSTINC) begin
                        n.cur = r.cur + dmc_pkg::ADDR_STEP;
                    end // other modes keep cur
                    if (last) begin
                        n.done_n = '0;
                        ev[dmc_pkg::IRQ_BLK_BIT] = 1'b1;
                        if (pp) begin
                            n.buf_sel = ~r.buf_sel;
                            n.cur = r.buf_sel ? r.sta : r.stb;
                        end else begin
                            n.cur = r.sta;
                        end
                        if (os && (!pp || r.buf_sel)) begin
                            n.en = 1'b0;
                            ev[dmc_pkg::IRQ_FIN_BIT] = 1'b1;
                        end
                    end else begin
                        n.done_n = r.done_n + 10'h001;
                    end
                end
            end
            default: n.state = dmc_pkg::ST_IDLE;
        endcase
        // software writes after the fsm so a force set beats the hardware clear
        if (reg_wr) begin
            case (reg_addr)
                dmc_pkg::OFS_CTRL: begin
                    n.en = reg_wdata[dmc_pkg::CTRL_EN_BIT];
                    n.amode = reg_wdata[dmc_pkg::CTRL_AM_LSB +: 2];
                    n.mode = reg_wdata[dmc_pkg::CTRL_MD_LSB +: 2];
                    if (!r.en && reg_wdata[dmc_pkg::CTRL_EN_BIT]) begin
                        n.cur = r.sta;
                        n.buf_sel = 1'b0;
                        n.done_n = '0;
                    end
                end
                dmc_pkg::OFS_REQ: begin
                    n.sel = reg_wdata[6:0];
                    if (reg_wdata[dmc_pkg::REQ_FORCE_BIT]) begin
                        n.force_x = 1'b1;
                    end
                end
                dmc_pkg::OFS_STA: begin
                    n.sta = reg_wdata;
                    if (!r.en) begin
                        n.cur = reg_wdata;
                    end
                end
                dmc_pkg::OFS_STB: n.stb = reg_wdata;
                dmc_pkg::OFS_PAD: n.pad = reg_wdata;
                dmc_pkg::OFS_CNT: n.cnt = reg_wdata[9:0];
                dmc_pkg::OFS_IEN: n.ien = reg_wdata[1:0];
                dmc_pkg::OFS_ICLR: n.istat = r.istat & ~reg_wdata[1:0];
                default: n.en = n.en;
            endcase
        end
        // a new event wins over a clear in the same cycle
        n.istat = n.istat | ev;
        n.irq = |(n.istat & n.ien);
        if (reg_rd) begin
            case (reg_addr)
                dmc_pkg::OFS_CTRL: n.rdata = ctrl_rd;
                dmc_pkg::OFS_REQ: n.rdata = {r.force_x, 8'h00, r.sel};
                dmc_pkg::OFS_STA: n.rdata = r.cur;
                dmc_pkg::OFS_STB: n.rdata = r.cur;
                dmc_pkg::OFS_PAD: n.rdata = r.pad;
                dmc_pkg::OFS_CNT: n.rdata = {6'h00, r.cnt};
                dmc_pkg::OFS_ISTAT: n.rdata = {14'h0, r.istat};
                dmc_pkg::OFS_IEN: n.rdata = {14'h0, r.ien};
                default: n.rdata = dmc_pkg::RST_REG;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign xfer_valid = r.xv;
    assign ram_addr = r.raddr;
    assign periph_addr = r.pad;
    assign channel_enable_bit = r.en;
    assign irq = r.irq;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    logic wr_force;
    assign wr_force = reg_wr && (reg_addr == dmc_pkg::OFS_REQ) && reg_wdata[dmc_pkg::REQ_FORCE_BIT];

    sequence s_idle_en;
        r.state == dmc_pkg::ST_IDLE && r.en;
    endsequence
    sequence s_done;
        r.state == dmc_pkg::ST_BUSY && xfer_done;
    endsequence
    sequence s_blk_end;
        s_done ##0 (r.done_n == r.cnt) && !reg_wr;
    endsequence

    property p_periph;
        s_idle_en ##0 (r.force_x || channel_transfer_request) && r.amode == dmc_pkg::AM_PERIPH
            |=> ram_addr == $past(periph_ram_addr);
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral address not used");

    property p_noinc;
        s_done ##0 r.amode == dmc_pkg::AM_NOINC && r.done_n != r.cnt && !reg_wr |=> r.cur == $past(r.cur);
    endproperty
    a_noinc: assert property (p_noinc) else $error("address moved without increment");

    property p_force;
        s_idle_en ##0 r.force_x |=> xfer_valid ##1 !xfer_valid;
    endproperty
    a_force: assert property (p_force) else $error("forced transfer not single");

    property p_noreq;
        s_idle_en ##0 !r.force_x && !channel_transfer_request |=> !xfer_valid;
    endproperty
    a_noreq: assert property (p_noreq) else $error("transfer without request");

    property p_force_keep;
        r.force_x && !(r.state == dmc_pkg::ST_BUSY && xfer_done && r.fxfer) |=> r.force_x;
    endproperty
    a_force_keep: assert property (p_force_keep) else $error("force dropped early");

    property p_force_clr;
        s_done ##0 r.fxfer && !wr_force |=> !r.force_x;
    endproperty
    a_force_clr: assert property (p_force_clr) else $error("force not cleared");

    property p_req_rb;
        reg_rd && reg_addr == dmc_pkg::OFS_REQ |=> reg_rdata[14:7] == 8'h00 && reg_rdata[6:0] == $past(r.sel);
    endproperty
    a_req_rb: assert property (p_req_rb) else $error("request readback wrong");

    property p_sta_rb;
        reg_rd && reg_addr == dmc_pkg::OFS_STA |=> reg_rdata == $past(r.cur);
    endproperty
    a_sta_rb: assert property (p_sta_rb) else $error("start readback not working address");

    property p_oneshot;
        s_blk_end ##0 r.mode == dmc_pkg::MD_OS |=> !channel_enable_bit;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot left enabled");

    property p_pingpong;
        s_blk_end ##0 r.mode[dmc_pkg::MD_PP_BIT] |=> r.buf_sel != $past(r.buf_sel);
    endproperty
    a_pingpong: assert property (p_pingpong) else $error("buffer did not alternate");

    property p_cont;
        s_blk_end ##0 r.en && !r.mode[dmc_pkg::MD_OS_BIT] |=> channel_enable_bit;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous mode stopped");

    property p_os_pp_mid;
        s_blk_end ##0 r.en && r.mode == dmc_pkg::MD_OS_PP && !r.buf_sel |=> channel_enable_bit;
    endproperty
    a_os_pp_mid: assert property (p_os_pp_mid) else $error("one-shot ping-pong stopped early");

    property p_os_pp_end;
        s_blk_end ##0 r.mode == dmc_pkg::MD_OS_PP && r.buf_sel |=> !channel_enable_bit;
    endproperty
    a_os_pp_end: assert property (p_os_pp_end) else $error("one-shot ping-pong left enabled");

    property p_count;
        s_done ##0 r.done_n != r.cnt && !reg_wr |=> r.done_n == $past(r.done_n) + 10'h001;
    endproperty
    a_count: assert property (p_count) else $error("transfer not counted");

    property p_reload;
        s_blk_end ##0 !r.mode[dmc_pkg::MD_PP_BIT] |=> r.cur == $past(r.sta);
    endproperty
    a_reload: assert property (p_reload) else $error("primary start not reloaded");

    property p_pp_load;
        s_blk_end ##0 r.mode[dmc_pkg::MD_PP_BIT] |=> r.cur == ($past(r.buf_sel) ? $past(r.sta) : $past(r.stb));
    endproperty
    a_pp_load: assert property (p_pp_load) else $error("wrong buffer start loaded");

    property p_en_load;
        reg_wr && reg_addr == dmc_pkg::OFS_CTRL && reg_wdata[dmc_pkg::CTRL_EN_BIT] && !r.en
            |=> r.cur == $past(r.sta) && !r.buf_sel && r.done_n == '0;
    endproperty
    a_en_load: assert property (p_en_load) else $error("enable did not start on primary");

    property p_sel;
        s_idle_en ##0 peripheral_request_lines[r.sel] |=> xfer_valid;
    endproperty
    a_sel: assert property (p_sel) else $error("selected request ignored");

    property p_pulse;
        xfer_valid |=> !xfer_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("start pulse too long");

    property p_stb;
        reg_wr && reg_addr == dmc_pkg::OFS_STB |=> r.stb == $past(reg_wdata);
    endproperty
    a_stb: assert property (p_stb) else $error("secondary start not held");

    property p_irq_blk;
        s_blk_end ##0 r.ien[dmc_pkg::IRQ_BLK_BIT] |=> irq;
    endproperty
    a_irq_blk: assert property (p_irq_blk) else $error("enabled block event without interrupt");
endmodule

/* dmc_ram_model.sv */
// dmc_ram_model: far-side transfer engine, answers each start with a done pulse
// assumes one transfer in flight; lat sets how slowly it answers
`timescale 1ns/1ps
module dmc_ram_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // transfer handshake
    input  wire logic       xfer_valid,
    input  wire logic [1:0] lat,
    output logic            xfer_done
);
    logic       busy_r;
    logic [1:0] cnt_r;

    // done is one cycle only, so the channel cannot count a transfer twice
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            busy_r    <= 1'b0;
            cnt_r     <= 2'h0;
            xfer_done <= 1'b0;
        end else begin
            xfer_done <= 1'b0;
            if (xfer_valid) begin
                busy_r <= 1'b1;
                cnt_r  <= lat;
            end else if (busy_r && cnt_r == 2'h0) begin
                busy_r    <= 1'b0;
                xfer_done <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end
endmodule

/* dmc_channel_tb.sv */
// dmc_channel_tb: self-checking bench for one dma channel
// assumes dmc_ram_model answers transfers; bench drives registers and requests
`timescale 1ns/1ps
module dmc_channel_tb;
    logic         ref_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic [3:0]   reg_addr = 4'h0;
    logic [15:0]  reg_wdata = 16'h0000;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [127:0] preq = '0;
    logic [15:0]  pra = 16'h0000;
    logic [1:0]   lat = 2'h0;
    logic         rd_d = 1'b0;
    logic [15:0]  reg_rdata, ram_addr, a, b, sel, ctl, periph_addr;
    logic         xfer_valid, xfer_done, channel_enable_bit, irq;
    logic [1:0]   am, md;
    logic [9:0]   c;
    int           bad_count = 0;
    int           checked = 0;
    int           nt;
    logic [15:0]  rq[$];
    logic [15:0]  xq[$];

    always #12.5 ref_clk = ~ref_clk;

    dmc_channel dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .peripheral_request_lines(preq),
        .periph_ram_addr(pra), .xfer_valid(xfer_valid), .ram_addr(ram_addr), .periph_addr(periph_addr),
        .xfer_done(xfer_done), .channel_enable_bit(channel_enable_bit), .irq(irq));
    dmc_ram_model ram_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .xfer_valid(xfer_valid), .lat(lat),
        .xfer_done(xfer_done));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // strobes drop for a cycle between accesses so no signal is set twice in a step
    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] ad, input logic [15:0] exp);
        rq.push_back(exp);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    function automatic logic [15:0] ea(input int k);
        int          blk;
        logic [15:0] base;
        blk  = k / (int'(c) + 1);
        base = (md[1] && blk[0]) ? b : a;
        ea   = am[1] ? pra : (am[0] ? base : base + 16'(k % (int'(c) + 1)));
    endfunction
    // transfer k: first by enabling with force pending, then request and force in turn
    task automatic xfer(input int k);
        int n;
        xq.push_back(ea(k));
        lat <= 2'($urandom_range(3));
        if (k == 0) wr(dmc_pkg::OFS_CTRL, ctl);
        else if (k % 2 == 0) wr(dmc_pkg::OFS_REQ, 16'h8000 | sel);
        else begin
            preq[sel[6:0]] <= 1'b1;
            @(posedge ref_clk);
            preq[sel[6:0]] <= 1'b0;
        end
        n = 0;
        while (!xfer_done && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        chk(16'(xfer_done), 16'h0001);
        if (k % 2 == 0) rd(dmc_pkg::OFS_REQ, sel);
        if (!am[1] && k < nt - 1) rd(dmc_pkg::OFS_STA, ea(k + 1));
    endtask

    always @(posedge ref_clk) begin
        rd_d <= reg_rd;
        if (rd_d && rq.size() > 0) chk(reg_rdata, rq.pop_front());
        if (xfer_valid) chk(ram_addr, (xq.size() > 0) ? xq.pop_front() : ~ram_addr);
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_sim;
    end

    initial begin
        void'($urandom(32'hd5e9));
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd(dmc_pkg::OFS_STA, 16'h0000);
        rd(dmc_pkg::OFS_REQ, 16'h0000);
        rd(4'hf, 16'h0000);
        wr(dmc_pkg::OFS_IEN, 16'h0002);
        for (int i = 0; i < 16; i++) begin
            md  = 2'(i % 4);
            am  = 2'(i / 4);
            a   = 16'($urandom);
            b   = 16'($urandom);
            c   = 10'((i % 3 == 0) ? 0 : $urandom_range(2, 1));
            sel = 16'($urandom_range(127));
            ctl = 16'h8000 | 16'(am) << 4 | 16'(md);
            pra  <= 16'($urandom);
            // every other line may be high; only the selected one may start a transfer
            preq <= {$urandom, $urandom, $urandom, $urandom} & ~(128'h1 << sel[6:0]);
            wr(dmc_pkg::OFS_STA, a);
            wr(dmc_pkg::OFS_STB, b);
            wr(dmc_pkg::OFS_CNT, 16'(c));
            wr(dmc_pkg::OFS_ICLR, 16'h0003);
            wr(dmc_pkg::OFS_REQ, 16'h8000 | sel);
            wr(dmc_pkg::OFS_REQ, 16'h7f80 | sel);
            rd(dmc_pkg::OFS_REQ, 16'h8000 | sel);
            rd(dmc_pkg::OFS_STA, a);
            rd(dmc_pkg::OFS_STB, a);
            rd(dmc_pkg::OFS_CNT, 16'(c));
            wr(dmc_pkg::OFS_PAD, ~a);
            chk(periph_addr, ~a);
            chk(16'(irq), 16'h0000);
            nt = (md[0] && !md[1] ? 1 : 2) * (int'(c) + 1);
            for (int k = 0; k < nt; k++) xfer(k);
            repeat (3) @(posedge ref_clk);
            chk(16'(channel_enable_bit), 16'(!md[0]));
            chk(16'(irq), 16'(md[0]));
            rd(dmc_pkg::OFS_ISTAT, {14'h0, md[0], 1'b1});
            wr(dmc_pkg::OFS_CTRL, 16'h0000);
        end
        chk(16'(xq.size()), 16'h0000);
        end_sim;
    end
endmodule
